// ==== shared/sfh_consts.vh ====
`ifndef SFH_CONSTS_VH
`define SFH_CONSTS_VH
// ********************
// Opcodes
// ********************
`define SFH_OP_RD_FAST2   8'h1B
`define SFH_OP_RD_FAST1   8'h0B
`define SFH_OP_RD_SLOW    8'h03
`define SFH_OP_RD_DUAL    8'h3B
`define SFH_OP_ERASE4K    8'h20
`define SFH_OP_ERASE32K   8'h52
`define SFH_OP_ERASE64K   8'hD8
`define SFH_OP_CHIP_ERA1  8'h60
`define SFH_OP_CHIP_ERA2  8'hC7
`define SFH_OP_PROG       8'h02
`define SFH_OP_PROG_DUAL  8'hA2
`define SFH_OP_SUSPEND    8'hB0
`define SFH_OP_RESUME     8'hD0
`define SFH_OP_WREN       8'h06
`define SFH_OP_WRDIS      8'h04
`define SFH_OP_PROTECT    8'h36
`define SFH_OP_UNPROTECT  8'h39
`define SFH_OP_RD_PROT    8'h3C
`define SFH_OP_LOCKDOWN   8'h33
`define SFH_OP_FREEZE     8'h34
`define SFH_OP_RD_LOCK    8'h35
`define SFH_OP_OTP_PROG   8'h9B
`define SFH_OP_OTP_READ   8'h77
`define SFH_OP_RD_STATUS  8'h05
`define SFH_OP_WR_STAT1   8'h01
`define SFH_OP_WR_STAT2   8'h31
`define SFH_OP_RESET      8'hF0
`define SFH_OP_READ_ID    8'h9F
`define SFH_OP_DEEP_PD    8'hB9
`define SFH_OP_WAKE       8'hAB
// ********************
// Framing and timing
// ********************
`define SFH_ADDR_BYTES    2'h3
`define SFH_ADDR_MASK     24'h1FFFFF
`define SFH_CLK_DIV_W     4
`define SFH_CLK_HALF      4'h4
`define SFH_FIFO_DEPTH    4
`define SFH_FIFO_AW       2
`endif

// ==== verilog/sfh_clk_div.v ====
`timescale 1ns/1ns
`default_nettype none
// ********************
// Half-period enable for the link clock
// ********************
module sfh_clk_div #(
  parameter W    = 4,
  parameter HALF = 4
) (
  input  wire         sys_clk,
  input  wire         rstn,
  input  wire         run,
  output reg          tick
);
  reg [W-1:0] cnt_ff;
  always @(posedge sys_clk) begin
    if (!rstn || !run) begin
      cnt_ff <= {W{1'b0}};
      tick   <= 1'b0;
    end else if (cnt_ff == HALF[W-1:0] - {{(W-1){1'b0}}, 1'b1}) begin
      cnt_ff <= {W{1'b0}};
      tick   <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + {{(W-1){1'b0}}, 1'b1};
      tick   <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== verilog/sfh_fifo.v ====
`timescale 1ns/1ns
`default_nettype none
// ********************
// Small synchronous FIFO
// ********************
module sfh_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             sys_clk,
  input  wire             rstn,
  input  wire [WIDTH-1:0] inData,
  input  wire             inValid,
  output wire             inReady,
  output reg  [WIDTH-1:0] outData,
  output wire             outValid,
  input  wire             outReady
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wrPtr_ff;
  reg [AW-1:0]    rdPtr_ff;
  reg [AW:0]      count_ff;
  wire            doWr;
  wire            doRd;
  assign inReady  = (count_ff != DEPTH[AW:0]);
  assign outValid = (count_ff != {(AW+1){1'b0}});
  assign doWr     = inValid && inReady;
  assign doRd     = outValid && outReady;
  always @* begin
    outData = mem[rdPtr_ff];
  end
  always @(posedge sys_clk) begin
    if (doWr) begin
      mem[wrPtr_ff] <= inData;
    end
  end
  always @(posedge sys_clk) begin
    if (!rstn) begin
      wrPtr_ff <= {AW{1'b0}};
      rdPtr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
    end else begin
      if (doWr) begin
        wrPtr_ff <= wrPtr_ff + {{(AW-1){1'b0}}, 1'b1};
      end
      if (doRd) begin
        rdPtr_ff <= rdPtr_ff + {{(AW-1){1'b0}}, 1'b1};
      end
      if (doWr && !doRd) begin
        count_ff <= count_ff + {{AW{1'b0}}, 1'b1};
      end else if (doRd && !doWr) begin
        count_ff <= count_ff - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule
`default_nettype wire

// ==== verilog/sfh_host.v ====
// Rules of the document
// R1 - Bus runs in mode 0: clock idles low, other mode unused.
// R2 - Device samples on rising edge, changes output on falling edge.
// R3 - Device accepts either idle clock level between transfers.
// R4 - Each operation: select low, one 8-bit opcode, then further bytes.
// R5 - Every opcode, address and data byte goes most significant bit first.
// R6 - Unsupported opcodes start nothing; host refuses to send them.
// R7 - After a bad opcode device ignores input until select cycles.
// R8 - Select released early aborts; host always completes the header.
// R9 - Addressed commands carry three address bytes, A23 down to A0.
// R10 - Top three address bits are ignored; host sends them as zero.
// R11 - Dual-input program: device output pin becomes second input line.
// R12 - Dual-output read: device input pin becomes second output line.
// R13 - Reads 1Bh, 0Bh, 03h: three address, two/one/zero dummy, data.
// R14 - Dual read 3Bh: three address, one dummy, data on two lines.
// R15 - Erase 20h, 52h, D8h: three address bytes only.
// R16 - Chip erase 60h or C7h: bare opcode.
// R17 - Program 02h single or A2h dual: address then 1 to 256 bytes.
// R18 - Suspend, resume, deep power-down, wake: bare opcodes.
// R19 - Write enable 06h and disable 04h: bare opcodes.
// R20 - Protect 36h, unprotect 39h: address only; 3Ch address then data.
// R21 - Lockdown 33h, freeze 34h: address, one byte; 35h reads data.
// R22 - OTP write 9Bh: address and data; read 77h: two dummy then data.
// R23 - Device drives its output only while returning read data.
// R24 - Device decodes opcode on eighth rising edge after select.
`timescale 1ns/1ns
`default_nettype none
`include "sfh_consts.vh"
module sfh_host (
  input  wire        sys_clk,
  input  wire        rstn,
  input  wire        cmdValid,
  output wire        cmdReady,
  input  wire [7:0]  cmdOpcode,
  input  wire [23:0] cmdAddr,
  input  wire [8:0]  cmdLen,
  output reg         cmdReject,
  input  wire [7:0]  wrData,
  input  wire        wrValid,
  output wire        wrReady,
  output wire [7:0]  rdData,
  output wire        rdValid,
  input  wire        rdReady,
  output reg         busy,
  output reg         flashCsN,
  output reg         flashSck,
  output reg         flashMosiOut,
  output reg         flashMosiOe,
  input  wire        flashMosiIn,
  output reg         flashMisoOut,
  output reg         flashMisoOe,
  input  wire        flashMisoIn
);
  // ********************
  // States
  // ********************
  localparam ST_IDLE = 6'b000001;
  localparam ST_OPC  = 6'b000010;
  localparam ST_ADDR = 6'b000100;
  localparam ST_DUMY = 6'b001000;
  localparam ST_DATA = 6'b010000;
  localparam ST_END  = 6'b100000;

  reg [5:0]  state_ff;
  reg [7:0]  opc_ff;
  reg [23:0] addr_ff;
  reg [1:0]  addrLeft_ff;
  reg [1:0]  dummyLeft_ff;
  reg [8:0]  dataLeft_ff;
  reg        isRead_ff;
  reg        isDual_ff;
  reg [7:0]  shOut_ff;
  reg [7:0]  shIn_ff;
  reg [2:0]  bitCnt_ff;
  reg        phase_ff;
  reg        misoS1_ff;
  reg        misoS2_ff;
  reg        mosiS1_ff;
  reg        mosiS2_ff;
  reg        pushRd_ff;
  reg        txHave_ff;
  reg [7:0]  txByte_ff;
  reg        txWait_ff;
  wire       tick;
  wire       txPop;

  // ********************
  // Opcode table
  // ********************
  reg       known;
  reg [1:0] nAddr;
  reg [1:0] nDummy;
  reg       hasData;
  reg       rdCmd;
  reg       dual;
  reg       oneByte;
  always @* begin
    known   = 1'b1;
    nAddr   = `SFH_ADDR_BYTES;
    nDummy  = 2'h0;
    hasData = 1'b0;
    rdCmd   = 1'b0;
    dual    = 1'b0;
    oneByte = 1'b0;
    case (cmdOpcode)
      `SFH_OP_RD_FAST2: begin nDummy = 2'h2; hasData = 1'b1; rdCmd = 1'b1; end // R13
      `SFH_OP_RD_FAST1: begin nDummy = 2'h1; hasData = 1'b1; rdCmd = 1'b1; end // R13
      `SFH_OP_RD_SLOW: begin hasData = 1'b1; rdCmd = 1'b1; end // R13
      `SFH_OP_RD_DUAL: begin
        nDummy = 2'h1; hasData = 1'b1; rdCmd = 1'b1; dual = 1'b1; // R14
      end
      `SFH_OP_ERASE4K, `SFH_OP_ERASE32K, `SFH_OP_ERASE64K,
      `SFH_OP_PROTECT, `SFH_OP_UNPROTECT: begin end // R15 R20
      `SFH_OP_CHIP_ERA1, `SFH_OP_CHIP_ERA2, `SFH_OP_SUSPEND,
      `SFH_OP_RESUME, `SFH_OP_DEEP_PD, `SFH_OP_WAKE,
      `SFH_OP_WREN, `SFH_OP_WRDIS: nAddr = 2'h0; // R16 R18 R19
      `SFH_OP_PROG: hasData = 1'b1; // R17
      `SFH_OP_PROG_DUAL: begin hasData = 1'b1; dual = 1'b1; end // R17 R11
      `SFH_OP_RD_PROT, `SFH_OP_RD_LOCK: begin
        hasData = 1'b1; rdCmd = 1'b1; // R20 R21
      end
      `SFH_OP_LOCKDOWN, `SFH_OP_FREEZE: begin
        hasData = 1'b1; oneByte = 1'b1; // R21
      end
      `SFH_OP_OTP_PROG: hasData = 1'b1; // R22
      `SFH_OP_OTP_READ: begin
        nDummy = 2'h2; hasData = 1'b1; rdCmd = 1'b1; // R22
      end
      `SFH_OP_RD_STATUS, `SFH_OP_READ_ID: begin
        nAddr = 2'h0; hasData = 1'b1; rdCmd = 1'b1;
      end
      `SFH_OP_WR_STAT1, `SFH_OP_WR_STAT2, `SFH_OP_RESET: begin
        nAddr = 2'h0; hasData = 1'b1; oneByte = 1'b1;
      end
      default: known = 1'b0; // R6
    endcase
  end

  // ********************
  // Helpers
  // ********************
  sfh_clk_div #(
    .W    (`SFH_CLK_DIV_W),
    .HALF (`SFH_CLK_HALF)
  ) u_div (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .run     (state_ff != ST_IDLE),
    .tick    (tick)
  );

  // Read bytes leave through the FIFO; full FIFO stalls the link clock
  wire rdFull;
  sfh_fifo #(
    .WIDTH (8),
    .DEPTH (`SFH_FIFO_DEPTH),
    .AW    (`SFH_FIFO_AW)
  ) u_fifo (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .inData   (shIn_ff),
    .inValid  (pushRd_ff),
    .inReady  (rdFull),
    .outData  (rdData),
    .outValid (rdValid),
    .outReady (rdReady)
  );

  assign cmdReady = (state_ff == ST_IDLE);
  wire   needTx   = (state_ff == ST_DATA) && !isRead_ff;
  assign wrReady  = needTx && !txHave_ff;
  assign txPop    = wrValid && wrReady;
  // Pause on the low half of a byte boundary when write data is missing or the read FIFO is full
  wire   stall    = (state_ff == ST_DATA) && !phase_ff && bitCnt_ff == 3'h0
                    && (isRead_ff ? !rdFull : txWait_ff);
  wire   step     = tick && !stall;

  // Sampled inputs go through two flops first
  always @(posedge sys_clk) begin
    if (!rstn) begin
      misoS1_ff <= 1'b0;
      misoS2_ff <= 1'b0;
      mosiS1_ff <= 1'b0;
      mosiS2_ff <= 1'b0;
    end else begin
      misoS1_ff <= flashMisoIn;
      misoS2_ff <= misoS1_ff;
      mosiS1_ff <= flashMosiIn;
      mosiS2_ff <= mosiS1_ff;
    end
  end

  // ********************
  // Sequencer
  // ********************
  wire [2:0] lastBit = isDual_ff ? 3'h3 : 3'h7;
  always @(posedge sys_clk) begin
    if (!rstn) begin
      state_ff     <= ST_IDLE;
      opc_ff       <= 8'h00;
      addr_ff      <= 24'h000000;
      addrLeft_ff  <= 2'h0;
      dummyLeft_ff <= 2'h0;
      dataLeft_ff  <= 9'h000;
      isRead_ff    <= 1'b0;
      isDual_ff    <= 1'b0;
      shOut_ff     <= 8'h00;
      shIn_ff      <= 8'h00;
      bitCnt_ff    <= 3'h0;
      phase_ff     <= 1'b0;
      pushRd_ff    <= 1'b0;
      txHave_ff    <= 1'b0;
      txByte_ff    <= 8'h00;
      txWait_ff    <= 1'b0;
      cmdReject    <= 1'b0;
      busy         <= 1'b0;
      flashCsN     <= 1'b1;
      flashSck     <= 1'b0;
      flashMosiOut <= 1'b0;
      flashMosiOe  <= 1'b0;
      flashMisoOut <= 1'b0;
      flashMisoOe  <= 1'b0;
    end else begin
      pushRd_ff <= 1'b0;
      cmdReject <= 1'b0;
      if (txPop) begin
        txHave_ff <= 1'b1;
        txByte_ff <= wrData;
      end
      case (state_ff)
        ST_IDLE: begin
          flashCsN <= 1'b1;
          flashSck <= 1'b0; // R1 R3
          busy     <= 1'b0;
          if (cmdValid && !known) begin
            cmdReject <= 1'b1; // R6 R7
          end else if (cmdValid) begin
            state_ff     <= ST_OPC; // R4
            busy         <= 1'b1;
            flashCsN     <= 1'b0;
            opc_ff       <= cmdOpcode;
            addr_ff      <= cmdAddr & `SFH_ADDR_MASK; // R10
            addrLeft_ff  <= nAddr; // R9
            dummyLeft_ff <= nDummy;
            dataLeft_ff  <= !hasData ? 9'h000 :
                            (oneByte ? 9'h001 : cmdLen); // R17
            isRead_ff    <= rdCmd;
            isDual_ff    <= 1'b0;
            shOut_ff     <= {cmdOpcode[6:0], 1'b0};
            flashMosiOut <= cmdOpcode[7]; // R5
            flashMosiOe  <= 1'b1;
            bitCnt_ff    <= 3'h0;
            phase_ff     <= 1'b0;
            txHave_ff    <= 1'b0;
          end
        end
        ST_OPC, ST_ADDR, ST_DUMY, ST_DATA: begin
          if (txWait_ff && txHave_ff) begin
            txWait_ff    <= 1'b0;
            txHave_ff    <= 1'b0;
            flashMisoOut <= txByte_ff[7]; // R11
            flashMosiOut <= isDual_ff ? txByte_ff[6] : txByte_ff[7]; // R5
            shOut_ff     <= isDual_ff ? {txByte_ff[5:0], 2'b00}
                                      : {txByte_ff[6:0], 1'b0};
          end
          if (step && !phase_ff) begin
            flashSck <= 1'b1; // R2
            phase_ff <= 1'b1;
            if (isDual_ff) begin
              shIn_ff <= {shIn_ff[5:0], misoS2_ff, mosiS2_ff}; // R12
            end else begin
              shIn_ff <= {shIn_ff[6:0], misoS2_ff};
            end
          end else if (step) begin
            flashSck  <= 1'b0; // R2
            phase_ff  <= 1'b0;
            bitCnt_ff <= bitCnt_ff + 3'h1;
            if (isDual_ff) begin
              flashMisoOut <= shOut_ff[7];
              flashMosiOut <= shOut_ff[6];
              shOut_ff     <= {shOut_ff[5:0], 2'b00};
            end else begin
              flashMosiOut <= shOut_ff[7];
              shOut_ff     <= {shOut_ff[6:0], 1'b0};
            end
            if (bitCnt_ff == lastBit) begin
              bitCnt_ff <= 3'h0;
              if (state_ff == ST_DATA) begin
                dataLeft_ff <= dataLeft_ff - 9'h001;
                pushRd_ff   <= isRead_ff;
              end
              // Next byte of the frame; header never cut short
              if (addrLeft_ff != 2'h0 && state_ff != ST_DATA) begin // R8
                state_ff    <= ST_ADDR;
                addrLeft_ff <= addrLeft_ff - 2'h1;
                flashMosiOut <= addr_ff[23];
                shOut_ff    <= {addr_ff[22:16], 1'b0};
                addr_ff     <= {addr_ff[15:0], 8'h00};
              end else if (dummyLeft_ff != 2'h0 && state_ff != ST_DATA) begin
                state_ff     <= ST_DUMY;
                dummyLeft_ff <= dummyLeft_ff - 2'h1;
                flashMosiOut <= 1'b0;
                shOut_ff     <= 8'h00;
              end else if (state_ff == ST_DATA ? dataLeft_ff > 9'h001
                                               : dataLeft_ff != 9'h000) begin
                state_ff  <= ST_DATA;
                isDual_ff <= (opc_ff == `SFH_OP_RD_DUAL) ||
                             (opc_ff == `SFH_OP_PROG_DUAL); // R11 R12
                if (isRead_ff) begin
                  flashMosiOe  <= (opc_ff != `SFH_OP_RD_DUAL); // R12 R23
                  flashMosiOut <= 1'b0;
                end else begin
                  // Loaded a cycle later, so a late byte stalls, not garbles
                  flashMisoOe <= (opc_ff == `SFH_OP_PROG_DUAL); // R11
                  txWait_ff   <= 1'b1;
                end
              end else begin
                state_ff <= ST_END;
              end
            end
          end
        end
        ST_END: begin
          flashCsN    <= 1'b1;
          busy        <= 1'b0;
          flashMosiOe <= 1'b0;
          flashMisoOe <= 1'b0;
          isDual_ff   <= 1'b0;
          state_ff    <= ST_IDLE;
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== tb/sfh_host_checker.sv ====
`timescale 1ns/1ns
`default_nettype none
// ********************
// Link framing checks
// ********************
module sfh_host_checker (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic cmdValid,
  input wire logic cmdReady,
  input wire logic cmdReject,
  input wire logic busy,
  input wire logic flashCsN,
  input wire logic flashSck,
  input wire logic flashMosiOut,
  input wire logic flashMosiOe,
  input wire logic flashMisoOe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence s_lead;
    !flashSck [*5] ##1 flashSck;
  endsequence
  sequence s_high;
    flashSck [*4] ##1 !flashSck;
  endsequence
  AST_SCK_IDLE: assert property (flashCsN |-> !flashSck)
    else $error("clock not idle low");
  AST_FIRST_RISE: assert property ($fell(flashCsN) |-> s_lead)
    else $error("first clock rise misplaced");
  AST_HALF_PERIOD: assert property ($rose(flashSck) |-> s_high)
    else $error("clock high half not four cycles");
  AST_DATA_STEADY: assert property (
    flashSck && $past(flashSck) && flashMosiOe |-> $stable(flashMosiOut))
    else $error("data moved while clock high");
  AST_REJECT_CAUSE: assert property (
    cmdReject |-> $past(cmdValid) && $past(cmdReady))
    else $error("reject without request");
  AST_REJECT_QUIET: assert property (cmdReject |-> flashCsN ##1 flashCsN)
    else $error("frame started on reject");
  AST_REJECT_PULSE: assert property (cmdReject |=> !cmdReject)
    else $error("reject longer than one cycle");
  AST_SELECT_BUSY: assert property (!flashCsN |-> busy)
    else $error("select low while not busy");
  AST_ONE_CMD: assert property (busy |-> !cmdReady)
    else $error("ready during a frame");
  AST_END_ON_LOW: assert property ($rose(flashCsN) |-> !$past(flashSck))
    else $error("deselect with clock high");
  AST_PINS_IDLE: assert property (
    flashCsN |-> !flashMosiOe && !flashMisoOe)
    else $error("pin driven while deselected");
endmodule
`default_nettype wire

// ==== tb/sfh_flash_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// ********************
// Serial flash stand-in
// ********************
module sfh_flash_model (
  input  wire logic csN,
  input  wire logic sck,
  input  wire logic mosiW,
  input  wire logic misoW,
  output logic      misoOut,
  output logic      misoOe,
  output logic      mosiOut,
  output logic      mosiOe
);
  int          n = 0, h = 8, j, nA = 0, nD;
  logic [7:0]  sh, opc, d;
  logic [23:0] adr;
  logic        rd = 1'b0, wr = 1'b0, dual = 1'b0, dead = 1'b0;
  logic [7:0]  rx[$];
  initial {misoOut, misoOe, mosiOut, mosiOe} = 4'h0;
  task automatic decode(input logic [7:0] o);
    opc = o;
    nA = 3;
    nD = 0;
    case (o)
      8'h1B, 8'h77: begin rd = 1'b1; nD = 2; end
      8'h0B: begin rd = 1'b1; nD = 1; end
      8'h3B: begin rd = 1'b1; nD = 1; dual = 1'b1; end
      8'h03, 8'h3C, 8'h35: rd = 1'b1;
      8'h02, 8'h9B, 8'h33, 8'h34: wr = 1'b1;
      8'hA2: begin wr = 1'b1; dual = 1'b1; end
      8'h20, 8'h52, 8'hD8, 8'h36, 8'h39: nA = 3;
      8'h60, 8'hC7, 8'hB0, 8'hD0, 8'hB9, 8'hAB, 8'h06, 8'h04: nA = 0;
      8'h05, 8'h9F: begin nA = 0; rd = 1'b1; end
      8'h01, 8'h31, 8'hF0: begin nA = 0; wr = 1'b1; end
      default: dead = 1'b1;
    endcase
    h = 8 + 8 * (nA + nD);
  endtask
  always @(negedge csN) begin
    n = 0;
    h = 8;
    nA = 0;
    {rd, wr, dual, dead} = 4'h0;
    rx = {};
  end
  always @(posedge csN) {misoOe, mosiOe} <= 2'h0;
  // Edge driven only, so either idle clock level is accepted
  always @(posedge sck) if (!csN && !dead) begin
    if (wr && dual && n >= h) sh = {sh[5:0], misoW, mosiW};
    else sh = {sh[6:0], mosiW};
    n = n + 1;
    if (n == 8) decode(sh);
    else if (n <= 8 + 8 * nA && n % 8 == 0) adr = {adr[15:0], sh};
    else if (wr && n > h && (n - h) % (dual ? 4 : 8) == 0) rx.push_back(sh);
  end
  always @(negedge sck) if (!csN && !dead && rd && n >= h) begin
    j = n - h;
    d = adr[7:0] + 8'(dual ? j / 4 : j / 8);
    if (dual) begin
      misoOut <= d[7 - 2 * (j % 4)];
      mosiOut <= d[6 - 2 * (j % 4)];
      mosiOe <= 1'b1;
    end else misoOut <= d[7 - j % 8];
    misoOe <= 1'b1;
  end
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) \
  begin \
    compares++; \
    if ((got) !== (ex)) begin \
      mismatches++; \
      $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); \
    end \
  end
// ********************
// Host bench
// ********************
module testbench;
  logic        sys_clk, flip = 1'b0, clash = 1'b0, hold = 1'b1;
  logic        rstn = 1'b0, cmdValid = 1'b0, rdReady = 1'b0, wrValid = 1'b0;
  logic [7:0]  cmdOpcode = 8'h00, wrData = 8'h00;
  logic [23:0] cmdAddr = 24'h000000;
  logic [8:0]  cmdLen = 9'h000;
  logic [7:0]  wq[$], rq[$];
  int          mismatches = 0, compares = 0, wi = 0, n1 = 0, n2 = 0;
  wire         cmdReady, cmdReject, wrReady, rdValid, busy, flashCsN;
  wire         flashSck, flashMosiOut, flashMosiOe, flashMisoOut;
  wire         flashMisoOe, fMisoOut, fMisoOe, fMosiOut, fMosiOe;
  wire [7:0]   rdData;
  // Released lines toggle so a stale level never reads as data
  wire mosiW = flashMosiOe ? flashMosiOut : fMosiOe ? fMosiOut : flip;
  wire misoW = flashMisoOe ? flashMisoOut : fMisoOe ? fMisoOut : flip;
  sfh_host dut (.sys_clk(sys_clk), .rstn(rstn), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmdOpcode(cmdOpcode), .cmdAddr(cmdAddr),
    .cmdLen(cmdLen), .cmdReject(cmdReject), .wrData(wrData),
    .wrValid(wrValid), .wrReady(wrReady), .rdData(rdData),
    .rdValid(rdValid), .rdReady(rdReady), .busy(busy),
    .flashCsN(flashCsN), .flashSck(flashSck), .flashMosiOut(flashMosiOut),
    .flashMosiOe(flashMosiOe), .flashMosiIn(mosiW),
    .flashMisoOut(flashMisoOut), .flashMisoOe(flashMisoOe),
    .flashMisoIn(misoW));
  sfh_flash_model fm (.csN(flashCsN), .sck(flashSck), .mosiW(mosiW),
    .misoW(misoW), .misoOut(fMisoOut), .misoOe(fMisoOe),
    .mosiOut(fMosiOut), .mosiOe(fMosiOe));
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) flip <= ~flip;
  always @(posedge sys_clk) if (rdValid && rdReady) rq.push_back(rdData);
  always @(posedge sys_clk)
    if (flashSck && (flashMosiOe && fMosiOe || flashMisoOe && fMisoOe))
      clash <= 1'b1;
  always @(posedge sys_clk) begin
    if (wrValid && wrReady) wi = wi + 1;
    wrValid <= !hold && wi < wq.size();
    wrData <= wi < wq.size() ? wq[wi] : 8'h00;
  end
  task close_out;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Both data sides stall long enough to fill the read buffer
  task automatic xfer(input logic [7:0] op, input logic [23:0] a, int len);
    int t;
    t = 0;
    rq = {};
    @(posedge sys_clk);
    cmdOpcode <= op;
    cmdAddr <= a;
    cmdLen <= 9'(len);
    cmdValid <= 1'b1;
    rdReady <= 1'b0;
    hold <= 1'b1;
    @(posedge sys_clk);
    cmdValid <= 1'b0;
    @(posedge sys_clk);
    while ((busy !== 1'b0 || rdValid !== 1'b0) && t < 9000) begin
      t++;
      if (t == 1000) n1 = fm.n;
      if (t == 1190) n2 = fm.n;
      hold <= (t < 1200);
      rdReady <= (t >= 1200);
      @(posedge sys_clk);
    end
    `CHK("done", 1, t < 9000)
  endtask
  task automatic t_reject;
    logic seen;
    seen = 1'b0;
    @(posedge sys_clk);
    cmdOpcode <= 8'hFF;
    cmdValid <= 1'b1;
    @(posedge sys_clk);
    cmdValid <= 1'b0;
    repeat (4) @(posedge sys_clk) seen |= cmdReject === 1'b1;
    `CHK("reject", 1'b1, seen)
    `CHK("select", 1'b1, flashCsN)
  endtask
  task automatic t_bare;
    logic [7:0] ops[8] = '{8'h60, 8'hC7, 8'hB0, 8'hD0, 8'hB9, 8'hAB,
                           8'h06, 8'h04};
    foreach (ops[i]) begin
      xfer(ops[i], 24'h000000, 0);
      `CHK("opcode", ops[i], fm.opc)
      `CHK("edges", 8, fm.n)
    end
  endtask
  task automatic t_erase;
    logic [7:0] ops[5] = '{8'h20, 8'h52, 8'hD8, 8'h36, 8'h39};
    foreach (ops[i]) begin
      xfer(ops[i], 24'hE5A3C7, 0);
      `CHK("addr", 24'h05A3C7, fm.adr)
      `CHK("edges", 32, fm.n)
    end
  endtask
  task automatic t_read;
    logic [7:0] ops[7] = '{8'h1B, 8'h0B, 8'h03, 8'h3B, 8'h3C, 8'h35, 8'h77};
    int dum[7] = '{2, 1, 0, 1, 0, 0, 2};
    foreach (ops[i]) begin
      xfer(ops[i], 24'h0010FC, 6);
      `CHK("edges", 8 * (4 + dum[i]) + (i == 3 ? 24 : 48), fm.n)
      `CHK("stall", n1, n2)
      `CHK("count", 6, rq.size())
      foreach (rq[k]) `CHK("rdata", 8'(8'hFC + k), rq[k])
    end
  endtask
  task automatic t_prog;
    logic [7:0] ops[5] = '{8'h02, 8'hA2, 8'h9B, 8'h33, 8'h34};
    int lens[5] = '{5, 5, 3, 1, 1};
    foreach (ops[i]) begin
      wq = {};
      for (int k = 0; k < lens[i]; k++) wq.push_back(8'(8'h3C + 37 * k));
      wi = 0;
      xfer(ops[i], 24'h000100, lens[i]);
      `CHK("edges", 32 + lens[i] * (i == 1 ? 4 : 8), fm.n)
      `CHK("stall", 32, n2)
      `CHK("wcount", lens[i], fm.rx.size())
      for (int k = 0; k < lens[i]; k++) `CHK("wdata", wq[k], fm.rx[k])
    end
    `CHK("clash", 1'b0, clash)
  endtask
  initial begin
    #4000000;
    mismatches++;
    close_out;
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    `CHK("idle", 4'h8, {flashCsN, flashSck, busy, flashMosiOe})
    t_reject;
    t_bare;
    t_erase;
    t_read;
    t_prog;
    close_out;
  end
endmodule
bind sfh_host sfh_host_checker chk (.sys_clk(sys_clk), .rstn(rstn),
  .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdReject(cmdReject),
  .busy(busy), .flashCsN(flashCsN), .flashSck(flashSck),
  .flashMosiOut(flashMosiOut), .flashMosiOe(flashMosiOe),
  .flashMisoOe(flashMisoOe));
`default_nettype wire
